// >>> hre_top.sv
// hre_top: three hdlc receivers behind one register window, with fifos
// assumes bit strobes from the framer on CLK and a same-clock host port
//
// Overview of operation
// - address match disabled stores every frame, mask mode ignored.
// - match mode 0 stores frames whose first byte is ones or either pattern.
// - match mode 1 compares only upper six bits against the patterns.
// - terminate abandons the frame, empties fifo, clears interrupts, rehunts.
// - terminate clears itself after one clock or on a config read.
// - enable low keeps receiver idle with fifo and interrupts cleared.
// - enable high starts hunting for an opening flag at once.
// - enable low then high acts like terminate.
// - shared low interrupt only on flag rise while interrupt enable set.
// - fill above threshold raises a condition until empty; zero means 128.
// - fifo empty flag is one when no bytes held.
// - a byte into a full fifo sets overwrite, resets fifo, clears two flags.
// - link change set on activating flag or abort; cleared by read.
// - packet stored set when a whole packet is in the fifo.
// - last byte status 000 data, 001 link up dummy, 010 abort dummy.
// - final byte status 100..111 from partial byte and check error.
// - receiver interrupt flag set by five sources, cleared on read.
// - earliest serial bit lands in bit 0 of the popped byte.
// - patterns hold first serial bit in bit 0, reset to all ones.
// - bank select chooses which of three receivers the window shows.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// first-word-fall-through fifo with flush
module hre_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 128
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } hre_fifo_state_type;

  hre_fifo_state_type s_reg, s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = s_reg.cnt != CW'(DEPTH);
  assign out_valid = s_reg.cnt != '0;
  assign out_data = mem[s_reg.rp];
  assign level = s_reg.cnt;
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  // pointer and count update
  always_comb begin
    s_next = s_reg;
    if (flush) begin
      s_next = '0;
    end else begin
      if (push) begin
        s_next.wp = (s_reg.wp == AW'(DEPTH-1)) ? '0 : s_reg.wp + 1'b1;
      end
      if (pop) begin
        s_next.rp = (s_reg.rp == AW'(DEPTH-1)) ? '0 : s_reg.rp + 1'b1;
      end
      if (push && !pop) begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end else if (pop && !push) begin
        s_next.cnt = s_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_reg.wp] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// one hdlc receiver with its registers and fifo
module hre_rx
  import hre_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_in,
  input wire logic bit_stb,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic irq
);
  localparam int LW = $clog2(DEPTH+1);
  localparam int SW = (LW > 8) ? LW : 8;

  typedef struct packed {
    logic address_match_enable;
    logic mm;
    logic tr;
    logic en;
    logic receiver_irq_enable;
    logic [6:0] thr;
    logic [7:0] pa;
    logic [7:0] sa;
    logic overwrite_flag;
    logic link_state_change_flag;
    logic packet_stored_flag;
    logic [2:0] pbs;
    logic receiver_irq_flag;
    logic int_pend;
    logic thr_hit;
    hre_rx_state_type st;
    logic link_up;
    logic [2:0] ones;
    logic [14:0] win;
    logic [3:0] nb;
    logic first;
    logic [7:0] held;
    logic held_v;
    logic [15:0] crc;
  } hre_rx_regs_type;

  hre_rx_regs_type s_reg, s_next;

  logic flush, wr_v, irq_set, kill, b, pop_req;
  logic [HRE_WORD_W-1:0] wr_d;
  logic fifo_in_ready, fifo_out_valid;
  logic [HRE_WORD_W-1:0] fifo_out;
  logic [LW-1:0] level;
  logic [SW-1:0] setpoint;
  logic [SW-1:0] level_w;
  logic [14:0] win_new;
  logic [7:0] byte_new;
  logic [3:0] resid;
  logic [15:0] crc_new;
  logic match;

  // bitwise crc over one byte, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      if (r[0] ^ d[k]) begin
        r = (r >> 1) ^ HRE_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  hre_fifo #(
    .WIDTH(HRE_WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(flush),
    .in_valid(wr_v),
    .in_ready(fifo_in_ready),
    .in_data(wr_d),
    .out_valid(fifo_out_valid),
    .out_ready(pop_req),
    .out_data(fifo_out),
    .level(level)
  );

  assign kill = !s_reg.en || s_reg.tr;
  assign pop_req = rd_en && addr == HRE_OFS_DATA && !kill;
  assign irq = s_reg.int_pend;
  // threshold zero stands for 128; compared wide so a shallow fifo never
  // wraps the set point down to a small value
  assign level_w = SW'(level);
  assign setpoint = (s_reg.thr == '0) ? SW'(HRE_SETPOINT_ZERO)
                                      : SW'(s_reg.thr);

  // register read data, taken before this cycle's side effects
  always_comb begin
    rdata = 8'h00;
    case (addr)
      HRE_OFS_CFG: begin
        rdata = {4'h0, s_reg.address_match_enable, s_reg.mm, s_reg.tr, s_reg.en};
      end
      HRE_OFS_IRQC: begin
        rdata = {s_reg.receiver_irq_enable, s_reg.thr};
      end
      HRE_OFS_STAT: begin
        rdata = {!fifo_out_valid, s_reg.overwrite_flag, s_reg.link_state_change_flag, s_reg.packet_stored_flag,
                 s_reg.pbs, s_reg.receiver_irq_flag};
      end
      HRE_OFS_DATA: begin
        rdata = (pop_req && fifo_out_valid) ? fifo_out[7:0]
                                            : 8'h00;
      end
      HRE_OFS_PRI: begin
        rdata = s_reg.pa;
      end
      HRE_OFS_SEC: begin
        rdata = s_reg.sa;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  // receiver state, registers and flags
  always_comb begin
    s_next = s_reg;
    flush = 1'b0;
    wr_v = 1'b0;
    wr_d = '0;
    irq_set = 1'b0;
    b = bit_in;
    win_new = {bit_in, s_reg.win[14:1]};
    byte_new = win_new[7:0];
    resid = 4'(s_reg.nb - HRE_LOOKAHEAD);
    crc_new = crc_byte(s_reg.crc, byte_new);
    match = 1'b1;

    // terminate lasts one clock
    if (s_reg.tr) begin
      s_next.tr = 1'b0;
    end

    // register writes
    if (wr_en) begin
      case (addr)
        HRE_OFS_CFG: begin
          s_next.address_match_enable = wdata[HRE_CFG_MEN];
          s_next.mm = wdata[HRE_CFG_MM];
          s_next.tr = wdata[HRE_CFG_TR];
          s_next.en = wdata[HRE_CFG_EN];
        end
        HRE_OFS_IRQC: begin
          s_next.receiver_irq_enable = wdata[HRE_IRQC_RECEIVER_IRQ_ENABLE];
          s_next.thr = wdata[HRE_IRQC_THR_MSB:0];
        end
        HRE_OFS_PRI: begin
          s_next.pa = wdata;
        end
        HRE_OFS_SEC: begin
          s_next.sa = wdata;
        end
        default: begin
        end
      endcase
    end

    // read side effects; later sets win over these clears
    if (rd_en) begin
      case (addr)
        HRE_OFS_CFG: begin
          s_next.tr = 1'b0;
        end
        HRE_OFS_STAT: begin
          s_next.overwrite_flag = 1'b0;
          s_next.link_state_change_flag = 1'b0;
          s_next.packet_stored_flag = 1'b0;
          s_next.receiver_irq_flag = 1'b0;
        end
        HRE_OFS_DATA: begin
          if (pop_req && fifo_out_valid) begin
            s_next.pbs = fifo_out[HRE_WORD_W-1:8];
          end
        end
        default: begin
        end
      endcase
    end

    // serial bit handling, only while running
    if (!kill && bit_stb) begin
      if (b) begin
        if (s_reg.ones != HRE_ABORT_ONES) begin
          s_next.ones = s_reg.ones + 1'b1;
        end
        if (s_reg.ones == HRE_FLAG_ONES) begin
          // seventh one: abort sequence
          s_next.st = HRE_HUNT;
          s_next.held_v = 1'b0;
          if (s_reg.link_up) begin
            s_next.link_up = 1'b0;
            wr_v = 1'b1;
            wr_d = {HRE_PBS_ABORT, HRE_DUMMY_BYTE};
            s_next.link_state_change_flag = 1'b1;
            irq_set = 1'b1;
          end
        end
      end else begin
        s_next.ones = '0;
      end

      if (!b && s_reg.ones == HRE_FLAG_ONES) begin
        // flag: close any frame, then open a fresh one
        if (s_reg.st == HRE_HUNT && !s_reg.link_up) begin
          s_next.link_up = 1'b1;
          wr_v = 1'b1;
          wr_d = {HRE_PBS_LINK_UP, HRE_DUMMY_BYTE};
          s_next.link_state_change_flag = 1'b1;
          irq_set = 1'b1;
        end else if (s_reg.st == HRE_FRAME && s_reg.held_v) begin
          wr_v = 1'b1;
          wr_d = {HRE_PBS_END, s_reg.held};
          wr_d[8+HRE_PBS_PARTIAL_BIT] = resid != '0;
          wr_d[8+HRE_PBS_FCS_BIT] = s_reg.crc != HRE_CRC_GOOD;
          s_next.packet_stored_flag = 1'b1;
          irq_set = 1'b1;
        end
        s_next.st = HRE_FRAME;
        s_next.nb = '0;
        s_next.first = 1'b1;
        s_next.held_v = 1'b0;
        s_next.crc = HRE_CRC_INIT;
      end else if (s_reg.st == HRE_FRAME && s_reg.ones != HRE_FLAG_ONES &&
                   !(!b && s_reg.ones == HRE_STUFF_ONES)) begin
        // data bit after zero removal
        s_next.win = win_new;
        s_next.nb = s_reg.nb + 1'b1;
        if (s_reg.nb + 1'b1 == HRE_BYTE_READY) begin
          s_next.nb = HRE_BYTE_READY - HRE_BYTE_BITS;
          if (s_reg.first && s_reg.address_match_enable) begin
            if (s_reg.mm) begin
              match = byte_new[7:2] == 6'h3f ||
                      byte_new[7:2] == s_reg.pa[7:2] ||
                      byte_new[7:2] == s_reg.sa[7:2];
            end else begin
              match = byte_new == 8'hff || byte_new == s_reg.pa ||
                      byte_new == s_reg.sa;
            end
          end
          s_next.first = 1'b0;
          if (!match) begin
            s_next.st = HRE_SKIP;
          end else begin
            // hold one byte back so the last can carry its status
            if (s_reg.held_v) begin
              wr_v = 1'b1;
              wr_d = {HRE_PBS_DATA, s_reg.held};
            end
            s_next.held = byte_new;
            s_next.held_v = 1'b1;
            s_next.crc = crc_new;
          end
        end
      end
    end

    // byte into a full fifo: overwrite
    if (wr_v && !fifo_in_ready) begin
      flush = 1'b1;
      s_next.overwrite_flag = 1'b1;
      s_next.link_state_change_flag = 1'b0;
      s_next.packet_stored_flag = 1'b0;
      irq_set = 1'b1;
    end

    // fill threshold condition held until empty
    if (level == '0) begin
      s_next.thr_hit = 1'b0;
    end else if (level_w > setpoint && !s_reg.thr_hit) begin
      s_next.thr_hit = 1'b1;
      irq_set = 1'b1;
    end

    // receiver flag and shared interrupt request
    if (irq_set) begin
      s_next.receiver_irq_flag = 1'b1;
      if (!s_reg.receiver_irq_flag && s_reg.receiver_irq_enable) begin
        s_next.int_pend = 1'b1;
      end
    end
    if (!s_next.receiver_irq_flag || !s_reg.receiver_irq_enable) begin
      s_next.int_pend = 1'b0;
    end

    // terminate or disable wipes the receiver
    if (kill) begin
      flush = 1'b1;
      s_next.overwrite_flag = 1'b0;
      s_next.link_state_change_flag = 1'b0;
      s_next.packet_stored_flag = 1'b0;
      s_next.receiver_irq_flag = 1'b0;
      s_next.int_pend = 1'b0;
      s_next.thr_hit = 1'b0;
      s_next.st = HRE_HUNT;
      s_next.link_up = 1'b0;
      s_next.ones = '0;
      s_next.nb = '0;
      s_next.held_v = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.thr <= HRE_THR_RST;
      s_reg.pa <= HRE_PATTERN_RST;
      s_reg.sa <= HRE_PATTERN_RST;
      s_reg.st <= HRE_HUNT;
      s_reg.crc <= HRE_CRC_INIT;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// three receivers sharing one window
module hre_top
  import hre_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  input wire logic [1:0] BANK_SEL,
  input wire logic [hre_pkg::HRE_NUM_RX-1:0] RX_BIT,
  input wire logic [hre_pkg::HRE_NUM_RX-1:0] RX_STB,
  output logic [7:0] RDATA,
  output logic INT_N
);
  import hre_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic int_n;
  } hre_top_state_type;

  hre_top_state_type s_reg, s_next;
  logic [7:0] rd_mux [HRE_NUM_RX];
  logic [HRE_NUM_RX-1:0] irq_vec;

  // one receiver per bank
  for (genvar i = 0; i < HRE_NUM_RX; i++) begin : g_rx
    hre_rx #(
      .DEPTH(DEPTH)
    ) u_rx (
      .clk(CLK),
      .rst(RST),
      .bit_in(RX_BIT[i]),
      .bit_stb(RX_STB[i]),
      .wr_en(WR && BANK_SEL == 2'(i)),
      .rd_en(RD && BANK_SEL == 2'(i)),
      .addr(ADDR),
      .wdata(WDATA),
      .rdata(rd_mux[i]),
      .irq(irq_vec[i])
    );
  end

  // read mux and shared interrupt
  always_comb begin
    s_next = s_reg;
    s_next.int_n = !(|irq_vec);
    if (RD) begin
      s_next.rdata = 8'h00;
      for (int i = 0; i < HRE_NUM_RX; i++) begin
        if (BANK_SEL == 2'(i)) begin
          s_next.rdata = rd_mux[i];
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_reg.rdata <= 8'h00;
      s_reg.int_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign INT_N = s_reg.int_n;
endmodule

// >>> hre_pkg.sv
// hre_pkg: constants and types shared by the hdlc receive engine files
// assumes an 8-bit register port with the same offsets on ADDR for every channel, chosen by BANK_SEL
package hre_pkg;

  // register offsets inside one channel window
  localparam logic [7:0] HRE_OFS_CFG = 8'h48;
  localparam logic [7:0] HRE_OFS_IRQC = 8'h49;
  localparam logic [7:0] HRE_OFS_STAT = 8'h4a;
  localparam logic [7:0] HRE_OFS_DATA = 8'h4b;
  localparam logic [7:0] HRE_OFS_PRI = 8'h4c;
  localparam logic [7:0] HRE_OFS_SEC = 8'h4d;

  // receiver_config fields
  localparam int HRE_CFG_MEN = 3;
  localparam int HRE_CFG_MM = 2;
  localparam int HRE_CFG_TR = 1;
  localparam int HRE_CFG_EN = 0;
  // receiver_irq_control fields
  localparam int HRE_IRQC_RECEIVER_IRQ_ENABLE = 7;
  localparam int HRE_IRQC_THR_MSB = 6;
  // receiver_status fields
  localparam int HRE_STAT_FE = 7;
  localparam int HRE_STAT_OVR = 6;
  localparam int HRE_STAT_LINK_STATE_CHANGE_FLAG = 5;
  localparam int HRE_STAT_PACKET_STORED_FLAG = 4;
  localparam int HRE_STAT_PBS_LSB = 1;
  localparam int HRE_STAT_RECEIVER_IRQ_FLAG = 0;

  // reset values
  localparam logic [7:0] HRE_PATTERN_RST = 8'hff;
  localparam logic [6:0] HRE_THR_RST = 7'h00;

  // last byte status codes
  localparam logic [2:0] HRE_PBS_DATA = 3'h0;
  localparam logic [2:0] HRE_PBS_LINK_UP = 3'h1;
  localparam logic [2:0] HRE_PBS_ABORT = 3'h2;
  localparam logic [2:0] HRE_PBS_END = 3'h4;
  localparam int HRE_PBS_PARTIAL_BIT = 0;
  localparam int HRE_PBS_FCS_BIT = 1;
  localparam logic [7:0] HRE_DUMMY_BYTE = 8'h00;

  // bit level framing
  localparam logic [2:0] HRE_STUFF_ONES = 3'h5;
  localparam logic [2:0] HRE_FLAG_ONES = 3'h6;
  localparam logic [2:0] HRE_ABORT_ONES = 3'h7;
  localparam logic [3:0] HRE_LOOKAHEAD = 4'h7;
  localparam logic [3:0] HRE_BYTE_READY = 4'hf;
  localparam logic [3:0] HRE_BYTE_BITS = 4'h8;

  // frame check sequence, lsb first
  localparam logic [15:0] HRE_CRC_INIT = 16'hffff;
  localparam logic [15:0] HRE_CRC_POLY = 16'h8408;
  localparam logic [15:0] HRE_CRC_GOOD = 16'hf0b8;

  // fill threshold value zero stands for this set point
  localparam int HRE_SETPOINT_ZERO = 128;
  // fifo word: status code above the byte
  localparam int HRE_WORD_W = 11;
  localparam int HRE_NUM_RX = 3;

  typedef enum logic [1:0] {
    HRE_HUNT,
    HRE_FRAME,
    HRE_SKIP
  } hre_rx_state_type;

endpackage

// >>> hre_top_asserts.sv
// hre_top_asserts: port level checks of the hdlc receive engine
// assumes a bind onto hre_top, one clock, synchronous reset
`timescale 1ns/1ps
module hre_top_asserts
  import hre_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  input wire logic [1:0] BANK_SEL,
  input wire logic [2:0] RX_BIT,
  input wire logic [2:0] RX_STB,
  input wire logic [7:0] RDATA,
  input wire logic INT_N
);
  logic [2:0] receiver_irq_enable_reg;
  logic receiver_irq_enable_any;

  ////////////////////////////////////////////////////////////////////////
  // shadow of the three interrupt enable bits
  always_ff @(posedge CLK) begin
    if (RST) begin
      receiver_irq_enable_reg <= 3'h0;
    end else if (WR && ADDR == HRE_OFS_IRQC && BANK_SEL != 2'h3) begin
      receiver_irq_enable_reg[BANK_SEL] <= WDATA[HRE_IRQC_RECEIVER_IRQ_ENABLE];
    end
  end
  assign receiver_irq_enable_any = |receiver_irq_enable_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // quiet cycle on the same bank, then a status read
  sequence s_quiet;
    !WR && $stable(BANK_SEL);
  endsequence
  sequence s_stat_rd;
    s_quiet ##1 RD && !WR && ADDR == HRE_OFS_STAT && $stable(BANK_SEL);
  endsequence
  sequence s_cfg_wr;
    WR && ADDR == HRE_OFS_CFG && BANK_SEL != 2'h3;
  endsequence

  property p_bank_none;
    RD && BANK_SEL == 2'h3 |=> RDATA == 8'h00;
  endproperty
  a_bank_none: assert property (p_bank_none)
    else $error("read with no bank selected not zero");

  property p_tr_self;
    RD && ADDR == HRE_OFS_CFG && !$past(WR) && !$past(WR, 2)
      |=> !RDATA[HRE_CFG_TR];
  endproperty
  a_tr_self: assert property (p_tr_self)
    else $error("terminate bit still set");

  property p_dis_clear;
    s_cfg_wr ##0 !WDATA[HRE_CFG_EN] ##1 s_stat_rd
      |=> (RDATA & 8'hf1) == 8'h80;
  endproperty
  a_dis_clear: assert property (p_dis_clear)
    else $error("disabled receiver status not cleared");

  property p_term_clear;
    s_cfg_wr ##0 WDATA[HRE_CFG_TR] ##1 s_stat_rd
      |=> (RDATA & 8'hf1) == 8'h80;
  endproperty
  a_term_clear: assert property (p_term_clear)
    else $error("terminate left fifo or flags");

  property p_pat_rb;
    WR && ADDR == HRE_OFS_PRI && BANK_SEL != 2'h3 ##1 s_quiet
      ##1 RD && !WR && ADDR == HRE_OFS_PRI && $stable(BANK_SEL)
      |=> RDATA == $past(WDATA, 3);
  endproperty
  a_pat_rb: assert property (p_pat_rb)
    else $error("primary pattern readback wrong");

  property p_rdata_hold;
    !RD |=> $stable(RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  property p_int_quiet;
    (!receiver_irq_enable_any) [*3] |-> INT_N;
  endproperty
  a_int_quiet: assert property (p_int_quiet)
    else $error("interrupt pin low with all enables off");

  property p_int_fall;
    $fell(INT_N) |-> receiver_irq_enable_any || $past(receiver_irq_enable_any);
  endproperty
  a_int_fall: assert property (p_int_fall)
    else $error("interrupt pin fell without an enable");
endmodule

// >>> hre_serial_src.sv
// hre_serial_src: bit stream source standing in for the receive framer
// assumes the bench queues bits per lane; one strobe per two clocks
`timescale 1ns/1ps
module hre_serial_src (
  input wire logic clk,
  output logic [2:0] bit_o,
  output logic [2:0] stb_o
);
  logic [2:0] q[$];
  logic [2:0] nb, ns, e;
  logic ph;

  // lane number above the bit
  task automatic push(input int l, input logic b);
    q.push_back({l[1:0], b});
  endtask

  initial begin
    ph = 1'b0;
    bit_o = 3'h0;
    stb_o = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // lines without a strobe toggle so stale bits never look valid
  always @(posedge clk) begin
    nb = ~bit_o;
    ns = 3'h0;
    if (ph && q.size() != 0) begin
      e = q.pop_front();
      nb[e[2:1]] = e[0];
      ns[e[2:1]] = 1'b1;
    end
    ph <= ~ph;
    bit_o <= nb;
    stb_o <= ns;
  end
endmodule

// >>> testbench.sv
// testbench: self-checking bench of hre_top with a queue model
// assumes hre_pkg, hre_top, hre_serial_src, hre_top_asserts compiled
`timescale 1ns/1ps
module testbench;
  import hre_pkg::*;
  logic CLK, RST, WR, RD, INT_N, ok, bad;
  logic [7:0] ADDR, WDATA, RDATA, pri, sec, rv, ad, ev;
  logic [1:0] BANK_SEL, m;
  logic [2:0] RX_BIT, RX_STB, up;
  logic [31:0] seed;
  logic [10:0] exp_q[$];
  int mismatches, samples_checked, cycles, ones, bk, res;

  hre_top #(.DEPTH(8)) hre_top_i (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WR(WR), .RD(RD), .WDATA(WDATA), .BANK_SEL(BANK_SEL), .RX_BIT(RX_BIT),
    .RX_STB(RX_STB), .RDATA(RDATA), .INT_N(INT_N));
  hre_serial_src hre_serial_src_i (.clk(CLK), .bit_o(RX_BIT),
    .stb_o(RX_STB));

  ////////////////////////////////////////////////////////////////////////
  // clock and run limit
  initial CLK = 1'b0;
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  // serial bits, first bit lowest, zero after five ones when stuffing
  task automatic put(input int l, input logic [7:0] v, input int n,
                     input bit stf);
    for (int i = 0; i < n; i++) begin
      hre_serial_src_i.push(l, v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (stf && ones == 5) begin
        hre_serial_src_i.push(l, 1'b0);
        ones = 0;
      end
    end
  endtask

  task automatic frame(input int l, input logic [7:0] adr, input bit acc,
                       input bit bd, input int rs, input int n);
    logic [7:0] d[$];
    logic [15:0] c;
    d = {adr};
    repeat (n) d.push_back(rnd());
    c = 16'hffff;
    foreach (d[k]) for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ d[k][i]) ? HRE_CRC_POLY : 16'h0000);
    c = ~c ^ {15'h0000, bd};
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
    put(l, 8'h7e, 8, 0);
    if (!up[l]) exp_q.push_back({HRE_PBS_LINK_UP, HRE_DUMMY_BYTE});
    up[l] = 1'b1;
    foreach (d[k]) begin
      put(l, d[k], 8, 1);
      if (acc) exp_q.push_back({k == d.size() - 1 ?
        {1'b1, bd, rs != 0} : HRE_PBS_DATA, d[k]});
    end
    put(l, 8'h00, rs, 1);
    put(l, 8'h7e, 8, 0);
    put(l, 8'h7e, 8, 0);
    while (hre_serial_src_i.q.size() != 0) @(posedge CLK);
    repeat (20) @(posedge CLK);
  endtask

  // pop every expected byte and compare byte and status code
  task automatic drain();
    logic [10:0] e;
    while (exp_q.size() != 0) begin
      e = exp_q.pop_front();
      repeat (15) @(posedge CLK);
      rd(HRE_OFS_DATA, rv);
      chk("data byte", rv, e[7:0]);
      rd(HRE_OFS_STAT, rv);
      chk("byte status", {5'h00, rv[3:1]}, {5'h00, e[10:8]});
    end
    rd(HRE_OFS_STAT, rv);
    chk("fifo empty", rv & 8'h80, 8'h80);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {WR, RD, ADDR, WDATA, BANK_SEL} = '0;
    RST = 1'b1;
    seed = 32'h00001bc4;
    up = 3'h0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    // reset values and bank window
    for (int b = 0; b < 4; b++) begin
      BANK_SEL <= b[1:0];
      for (int a = 8'h48; a < 8'h4f; a++) begin
        rd(a[7:0], rv);
        ev = (a == 8'h4c || a == 8'h4d) ? 8'hff : 8'h00;
        if (a == 8'h4a) ev = 8'h80;
        if (b == 3) ev = 8'h00;
        chk("reset value", a == 8'h4a ? rv & 8'hf1 : rv, ev);
      end
    end
    rv = rnd();
    pri = {2'b01, rv[5:0]};
    rv = rnd();
    sec = {2'b10, rv[5:0]};
    for (int b = 0; b < 3; b++) begin
      BANK_SEL <= b[1:0];
      wr(HRE_OFS_IRQC, b == 0 ? 8'h80 : 8'h00);
      wr(HRE_OFS_PRI, pri);
      rd(HRE_OFS_PRI, rv);
      chk("primary pattern", rv, pri);
      wr(HRE_OFS_SEC, sec);
      wr(HRE_OFS_CFG, 8'h01);
    end
    // address match modes over the three banks
    for (int i = 0; i < 9; i++) begin
      bk = i % 3;
      BANK_SEL <= bk[1:0];
      bad = 1'b0;
      res = 0;
      ok = 1'b1;
      case (i)
        0, 1: begin m = i[1:0]; ad = rnd(); end
        2: begin m = 2'b10; ad = pri; end
        3: begin m = 2'b10; ad = 8'hff; bad = 1'b1; end
        4: begin m = 2'b10; ad = sec ^ 8'h01; ok = 1'b0; end
        5: begin m = 2'b11; ad = pri ^ 8'h03; res = 3; end
        6: begin m = 2'b11; ad = sec ^ 8'h02; bad = 1'b1; res = 3; end
        7: begin m = 2'b11; ad = pri ^ 8'h04; ok = 1'b0; end
        default: begin m = 2'b11; ad = 8'hfc; end
      endcase
      wr(HRE_OFS_CFG, {4'h0, m, 2'b01});
      frame(bk, ad, ok, bad, res, 2);
      if (i == 0) chk("irq pin low", {7'h00, INT_N}, 8'h00);
      rd(HRE_OFS_STAT, rv);
      chk("frame flags", rv & 8'h31, {2'h0, i < 3, ok, 3'h0, ok});
      repeat (3) @(posedge CLK);
      chk("irq pin high", {7'h00, INT_N}, 8'h01);
      drain();
    end
    // abort on a live link
    BANK_SEL <= 2'h0;
    put(0, 8'hff, 8, 0);
    repeat (40) @(posedge CLK);
    exp_q.push_back({HRE_PBS_ABORT, HRE_DUMMY_BYTE});
    up[0] = 1'b0;
    rd(HRE_OFS_STAT, rv);
    chk("abort flags", rv & 8'h21, 8'h21);
    drain();
    // terminate with bytes pending
    BANK_SEL <= 2'h1;
    frame(1, sec, 1, 0, 0, 2);
    wr(HRE_OFS_CFG, 8'h03);
    rd(HRE_OFS_STAT, rv);
    chk("terminate flush", rv & 8'hf1, 8'h80);
    rd(HRE_OFS_CFG, rv);
    chk("terminate clear", rv, 8'h01);
    exp_q.delete();
    up[1] = 1'b0;
    frame(1, rnd(), 1, 0, 0, 2);
    drain();
    // disable and enable again
    BANK_SEL <= 2'h2;
    frame(2, 8'hff, 1, 0, 0, 2);
    wr(HRE_OFS_CFG, 8'h00);
    rd(HRE_OFS_STAT, rv);
    chk("disable flush", rv & 8'hf1, 8'h80);
    wr(HRE_OFS_CFG, 8'h01);
    exp_q.delete();
    up[2] = 1'b0;
    frame(2, rnd(), 1, 0, 0, 2);
    drain();
    // more bytes than the fifo holds
    BANK_SEL <= 2'h0;
    frame(0, 8'hff, 1, 0, 0, 12);
    rd(HRE_OFS_STAT, rv);
    chk("overwrite set", rv & 8'h41, 8'h41);
    rd(HRE_OFS_STAT, rv);
    chk("overwrite clear", rv & 8'h40, 8'h00);
    finish_test();
  end
endmodule

bind hre_top hre_top_asserts #(.DEPTH(DEPTH)) hre_top_asserts_i (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA),
  .BANK_SEL(BANK_SEL), .RX_BIT(RX_BIT), .RX_STB(RX_STB), .RDATA(RDATA),
  .INT_N(INT_N));
